// ==== jrx_pkg.sv ====
package jrx_pkg;

	// ************************************************************
	// datapath widths
	// ************************************************************
	localparam int NUM_LANES = 8;
	localparam int LANE_W    = 8;
	localparam int NUM_CONV  = 4;
	localparam int SAMPLE_W  = 16;
	localparam int ILAS_W    = 48;

	// ************************************************************
	// register offsets on the serial configuration port
	// ************************************************************
	localparam logic [14:0] ADDR_TPL_CONTROL    = 15'h032C;
	localparam logic [14:0] ADDR_TPL_REF_LOW    = 15'h032D;
	localparam logic [14:0] ADDR_TPL_REF_HIGH   = 15'h032E;
	localparam logic [14:0] ADDR_TPL_RESULT     = 15'h032F;
	localparam logic [14:0] ADDR_LANE_INVERT    = 15'h0334;
	localparam logic [14:0] ADDR_RX_DEVICE_ID   = 15'h0400;
	localparam logic [14:0] ADDR_RX_BANK_ID     = 15'h0401;
	localparam logic [14:0] ADDR_RX_LANE_ADJUST = 15'h0402;
	localparam logic [14:0] ADDR_RX_SCR_LANES   = 15'h0403;
	localparam logic [14:0] ADDR_RX_OCTETS      = 15'h0404;
	localparam logic [14:0] ADDR_RX_FRAMES_MF   = 15'h0405;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_CLEAR_BIT  = 1;
	localparam int CTRL_SEL_LSB    = 2;
	localparam int CTRL_SEL_W      = 2;
	localparam int RESULT_FAIL_BIT = 0;
	localparam int ADJ_DIR_BIT     = 6;
	localparam int PHASE_ADJ_BIT   = 5;
	localparam int SCRAMBLE_BIT    = 7;

	// received configuration octets, masks keep reserved bits zero
	localparam int ILAS_BYTE_DID   = 0;
	localparam int ILAS_BYTE_BID   = 1;
	localparam int ILAS_BYTE_LID   = 2;
	localparam int ILAS_BYTE_SCR_L = 3;
	localparam int ILAS_BYTE_F     = 4;
	localparam int ILAS_BYTE_K     = 5;
	localparam logic [7:0] MASK_LANE_ADJUST = 8'h7F;
	localparam logic [7:0] MASK_SCR_LANES   = 8'h9F;
	localparam logic [7:0] MASK_FRAMES_MF   = 8'h1F;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [7:0] RST_TPL_CONTROL = 8'h00;
	localparam logic [7:0] RST_TPL_REF     = 8'h00;
	localparam logic [7:0] RST_LANE_INVERT = 8'h00;
	localparam logic [7:0] RST_RX_FIELD    = 8'h00;

	// ************************************************************
	// serial frame: 16 instruction bits then 8 data bits
	// ************************************************************
	localparam logic [4:0] INSTR_BITS  = 5'h10;
	localparam logic [4:0] FRAME_BITS  = 5'h18;
	localparam int         READ_BIT    = 15;

endpackage

// ==== cfg_bus_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface cfg_bus_if;
	logic [14:0] addr;
	logic [7:0]  wdata;
	logic        wr;
	logic [7:0]  rdata;

	modport port_side (
		output addr,
		output wdata,
		output wr,
		input  rdata
	);
	modport reg_side (
		input  addr,
		input  wdata,
		input  wr,
		output rdata
	);
endinterface

`default_nettype wire

// ==== serial_cfg_port.sv ====
`timescale 1ns/1ps
`default_nettype none

module serial_cfg_port
	import jrx_pkg::*;
(
	input  wire logic      clk,
	input  wire logic      rst_n,
	input  wire logic      ce,
	input  wire logic      sclk,
	input  wire logic      cs_n,
	input  wire logic      sdi,
	output var  logic      sdo,
	output var  logic      sdo_oe,
	cfg_bus_if.port_side   bus
);

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic       sclk_meta_ff, sclk_sync_ff, sclk_prev_ff;
	logic       cs_meta_ff,   cs_sync_ff;
	logic       sdi_meta_ff,  sdi_sync_ff;

	// ************************************************************
	// frame state
	// ************************************************************
	logic [4:0]  cnt_ff,   nxt_cnt;
	logic [15:0] shift_ff, nxt_shift;
	logic [14:0] addr_ff,  nxt_addr;
	logic [7:0]  wdata_ff, nxt_wdata;
	logic [7:0]  out_ff,   nxt_out;
	logic        read_ff,  nxt_read;
	logic        load_ff,  nxt_load;
	logic        wr_ff,    nxt_wr;
	logic        sdo_ff,   nxt_sdo;
	logic        oe_ff,    nxt_oe;
	logic        rise, fall;

	assign rise = sclk_sync_ff & ~sclk_prev_ff;
	assign fall = ~sclk_sync_ff & sclk_prev_ff;

	always_comb begin
		nxt_cnt   = cnt_ff;
		nxt_shift = shift_ff;
		nxt_addr  = addr_ff;
		nxt_wdata = wdata_ff;
		nxt_out   = out_ff;
		nxt_read  = read_ff;
		nxt_load  = 1'b0;
		nxt_wr    = 1'b0;
		nxt_sdo   = sdo_ff;
		nxt_oe    = oe_ff;
		if (cs_sync_ff) begin
			nxt_cnt  = 5'h00;
			nxt_read = 1'b0;
			nxt_oe   = 1'b0;
		end else begin
			if (rise && cnt_ff < FRAME_BITS) begin
				nxt_shift = {shift_ff[14:0], sdi_sync_ff};
				nxt_cnt   = 5'(cnt_ff + 5'h01);
				if (cnt_ff == 5'(INSTR_BITS - 5'h01)) begin
					nxt_addr = nxt_shift[14:0];
					nxt_read = nxt_shift[READ_BIT];
					nxt_load = nxt_shift[READ_BIT];
				end
				if (cnt_ff == 5'(FRAME_BITS - 5'h01) && !read_ff) begin
					nxt_wdata = nxt_shift[7:0];
					nxt_wr    = 1'b1;
				end
			end
			// read data is sampled one cycle after the address settles
			if (load_ff)
				nxt_out = bus.rdata;
			if (fall && read_ff && cnt_ff >= INSTR_BITS) begin
				nxt_sdo = out_ff[7];
				nxt_out = {out_ff[6:0], 1'b0};
				nxt_oe  = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_meta_ff <= 1'b0;
			sclk_sync_ff <= 1'b0;
			sclk_prev_ff <= 1'b0;
			cs_meta_ff   <= 1'b1;
			cs_sync_ff   <= 1'b1;
			sdi_meta_ff  <= 1'b0;
			sdi_sync_ff  <= 1'b0;
			cnt_ff       <= 5'h00;
			shift_ff     <= 16'h0000;
			addr_ff      <= 15'h0000;
			wdata_ff     <= 8'h00;
			out_ff       <= 8'h00;
			read_ff      <= 1'b0;
			load_ff      <= 1'b0;
			wr_ff        <= 1'b0;
			sdo_ff       <= 1'b0;
			oe_ff        <= 1'b0;
		end else if (ce) begin
			sclk_meta_ff <= sclk;
			sclk_sync_ff <= sclk_meta_ff;
			sclk_prev_ff <= sclk_sync_ff;
			cs_meta_ff   <= cs_n;
			cs_sync_ff   <= cs_meta_ff;
			sdi_meta_ff  <= sdi;
			sdi_sync_ff  <= sdi_meta_ff;
			cnt_ff       <= nxt_cnt;
			shift_ff     <= nxt_shift;
			addr_ff      <= nxt_addr;
			wdata_ff     <= nxt_wdata;
			out_ff       <= nxt_out;
			read_ff      <= nxt_read;
			load_ff      <= nxt_load;
			wr_ff        <= nxt_wr;
			sdo_ff       <= nxt_sdo;
			oe_ff        <= nxt_oe;
		end
	end

	assign bus.addr  = addr_ff;
	assign bus.wdata = wdata_ff;
	assign bus.wr    = wr_ff;
	assign sdo       = sdo_ff;
	assign sdo_oe    = oe_ff;

endmodule

`default_nettype wire

// ==== jesd_rx_test_and_ilas_capture.sv ====
// Behaviour
// RULE1: software writes an 8-bit register holding the upper byte of the expected sample.
// RULE2: the result bit at position 0 reads 0 when the chosen sample matched and 1 when it differed.
// RULE3: each set bit n of the 8-bit inversion control inverts the data of logical lane n.
// RULE4: the device identifier from the lane 0 configuration data is readable.
// RULE5: the bank identifier from lane 0, extending the device identifier, is readable.
// RULE6: bit 6 shows the received direction in which the local multiframe clock should move.
// RULE7: bit 5 shows the received phase adjustment request from lane 0.
// RULE8: a 5-bit field shows the lane number received in the lane 0 configuration data.
// RULE9: bit 7 shows the received scrambling status, 1 meaning enabled.
// RULE10: a 5-bit field shows the received lane count minus one.
// RULE11: an 8-bit field shows the received octets per frame minus one.
// RULE12: software writes an 8-bit register holding the lower byte of the expected sample.
// RULE13: a 2-bit selector picks which of four converter streams is compared.
// RULE14: the stored test result is cleared while the test clear bit is 1.
// RULE15: the comparison runs only while the test enable bit 0 is 1.
// RULE16: the lane 0 configuration fields are latched on arrival and held until the next or a reset.
`timescale 1ns/1ps
`default_nettype none

module jesd_rx_test_and_ilas_capture
	import jrx_pkg::*;
(
	input  wire logic                          SYS_CLK,
	input  wire logic                          RESET_N,
	input  wire logic                          CLK_EN,
	input  wire logic                          SPI_SCLK,
	input  wire logic                          SPI_CS_N,
	input  wire logic                          SPI_SDI,
	output var  logic                          SPI_SDO,
	output var  logic                          SPI_SDO_OE,
	input  wire logic [NUM_LANES*LANE_W-1:0]   LANE_DATA_IN,
	output var  logic [NUM_LANES*LANE_W-1:0]   LANE_DATA_OUT,
	input  wire logic                          SAMPLE_VALID,
	input  wire logic [NUM_CONV*SAMPLE_W-1:0]  SAMPLE_DATA,
	input  wire logic                          ILAS_CFG_VALID,
	input  wire logic [ILAS_W-1:0]             ILAS_CFG_DATA
);

	// ************************************************************
	// reset release
	// ************************************************************
	logic rst_meta_ff;
	logic rst_n;

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rst_meta_ff <= 1'b0;
			rst_n       <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n       <= rst_meta_ff;
		end
	end

	// ************************************************************
	// serial configuration port
	// ************************************************************
	cfg_bus_if bus ();

	serial_cfg_port u_port (
		.clk    (SYS_CLK),
		.rst_n  (rst_n),
		.ce     (CLK_EN),
		.sclk   (SPI_SCLK),
		.cs_n   (SPI_CS_N),
		.sdi    (SPI_SDI),
		.sdo    (SPI_SDO),
		.sdo_oe (SPI_SDO_OE),
		.bus    (bus.port_side)
	);

	// ************************************************************
	// software written registers
	// ************************************************************
	logic [7:0] tpl_control_ff,        nxt_tpl_control;
	logic [7:0] expected_sample_low,   nxt_expected_sample_low;
	logic [7:0] expected_sample_high,  nxt_expected_sample_high;
	logic [7:0] lane_invert_mask,      nxt_lane_invert_mask;

	always_comb begin
		nxt_tpl_control          = tpl_control_ff;
		nxt_expected_sample_low  = expected_sample_low;
		nxt_expected_sample_high = expected_sample_high;
		nxt_lane_invert_mask     = lane_invert_mask;
		if (bus.wr) begin
			case (bus.addr)
				ADDR_TPL_CONTROL:  nxt_tpl_control = bus.wdata;
				ADDR_TPL_REF_LOW:  nxt_expected_sample_low = bus.wdata; // RULE12
				ADDR_TPL_REF_HIGH: nxt_expected_sample_high = bus.wdata; // RULE1
				ADDR_LANE_INVERT:  nxt_lane_invert_mask = bus.wdata; // RULE3
				default: ;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			tpl_control_ff       <= RST_TPL_CONTROL;
			expected_sample_low  <= RST_TPL_REF;
			expected_sample_high <= RST_TPL_REF;
			lane_invert_mask     <= RST_LANE_INVERT;
		end else if (CLK_EN) begin
			tpl_control_ff       <= nxt_tpl_control;
			expected_sample_low  <= nxt_expected_sample_low;
			expected_sample_high <= nxt_expected_sample_high;
			lane_invert_mask     <= nxt_lane_invert_mask;
		end
	end

	// ************************************************************
	// short transport test
	// ************************************************************
	logic [CTRL_SEL_W-1:0] transport_test_converter_select;
	logic                  transport_test_enable;
	logic                  transport_test_clear;
	logic [SAMPLE_W-1:0]   chosen_sample;
	logic                  transport_test_mismatch, nxt_transport_test_mismatch;

	assign transport_test_converter_select =
		tpl_control_ff[CTRL_SEL_LSB +: CTRL_SEL_W];
	assign transport_test_enable = tpl_control_ff[CTRL_ENABLE_BIT];
	assign transport_test_clear  = tpl_control_ff[CTRL_CLEAR_BIT];
	assign chosen_sample =
		SAMPLE_DATA[{transport_test_converter_select, 4'h0} +: SAMPLE_W]; // RULE13

	// the failure is sticky so a single bad sample is not missed by a slow read
	always_comb begin
		nxt_transport_test_mismatch = transport_test_mismatch;
		if (transport_test_clear)
			nxt_transport_test_mismatch = 1'b0; // RULE14
		else if (transport_test_enable && SAMPLE_VALID && // RULE15
			chosen_sample != {expected_sample_high, expected_sample_low})
			nxt_transport_test_mismatch = 1'b1; // RULE2
	end

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n)
			transport_test_mismatch <= 1'b0;
		else if (CLK_EN)
			transport_test_mismatch <= nxt_transport_test_mismatch;
	end

	// ************************************************************
	// lane inversion
	// ************************************************************
	logic [NUM_LANES*LANE_W-1:0] lane_out_ff, nxt_lane_out;

	always_comb begin
		nxt_lane_out = LANE_DATA_IN;
		for (int n = 0; n < NUM_LANES; n++) begin
			nxt_lane_out[n*LANE_W +: LANE_W] = LANE_DATA_IN[n*LANE_W +: LANE_W]
				^ {LANE_W{lane_invert_mask[n]}}; // RULE3
		end
	end

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n)
			lane_out_ff <= '0;
		else if (CLK_EN)
			lane_out_ff <= nxt_lane_out;
	end

	assign LANE_DATA_OUT = lane_out_ff;

	// ************************************************************
	// lane 0 configuration capture
	// ************************************************************
	logic [7:0] rx_device_identifier, nxt_rx_device_identifier;
	logic [7:0] rx_bank_identifier,   nxt_rx_bank_identifier;
	logic [7:0] rx_lane_adjust_ff,    nxt_rx_lane_adjust;
	logic [7:0] rx_scr_lanes_ff,      nxt_rx_scr_lanes;
	logic [7:0] rx_octets_ff,         nxt_rx_octets;
	logic [7:0] rx_frames_mf_ff,      nxt_rx_frames_mf;
	logic       rx_adjust_direction;
	logic       rx_phase_adjust_request;
	logic [4:0] rx_lane_number;
	logic       rx_scramble_flag;
	logic [4:0] rx_lane_count;

	// a partial sequence never disturbs the held copy
	always_comb begin
		nxt_rx_device_identifier = rx_device_identifier;
		nxt_rx_bank_identifier   = rx_bank_identifier;
		nxt_rx_lane_adjust       = rx_lane_adjust_ff;
		nxt_rx_scr_lanes         = rx_scr_lanes_ff;
		nxt_rx_octets            = rx_octets_ff;
		nxt_rx_frames_mf         = rx_frames_mf_ff;
		if (ILAS_CFG_VALID) begin // RULE16
			nxt_rx_device_identifier = ILAS_CFG_DATA[ILAS_BYTE_DID*8 +: 8]; // RULE4
			nxt_rx_bank_identifier   = ILAS_CFG_DATA[ILAS_BYTE_BID*8 +: 8]; // RULE5
			nxt_rx_lane_adjust =
				ILAS_CFG_DATA[ILAS_BYTE_LID*8 +: 8] & MASK_LANE_ADJUST;
			nxt_rx_scr_lanes =
				ILAS_CFG_DATA[ILAS_BYTE_SCR_L*8 +: 8] & MASK_SCR_LANES;
			nxt_rx_octets = ILAS_CFG_DATA[ILAS_BYTE_F*8 +: 8]; // RULE11
			nxt_rx_frames_mf =
				ILAS_CFG_DATA[ILAS_BYTE_K*8 +: 8] & MASK_FRAMES_MF;
		end
	end

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			rx_device_identifier <= RST_RX_FIELD;
			rx_bank_identifier   <= RST_RX_FIELD;
			rx_lane_adjust_ff    <= RST_RX_FIELD;
			rx_scr_lanes_ff      <= RST_RX_FIELD;
			rx_octets_ff         <= RST_RX_FIELD;
			rx_frames_mf_ff      <= RST_RX_FIELD;
		end else if (CLK_EN) begin
			rx_device_identifier <= nxt_rx_device_identifier;
			rx_bank_identifier   <= nxt_rx_bank_identifier;
			rx_lane_adjust_ff    <= nxt_rx_lane_adjust;
			rx_scr_lanes_ff      <= nxt_rx_scr_lanes;
			rx_octets_ff         <= nxt_rx_octets;
			rx_frames_mf_ff      <= nxt_rx_frames_mf;
		end
	end

	assign rx_adjust_direction     = rx_lane_adjust_ff[ADJ_DIR_BIT]; // RULE6
	assign rx_phase_adjust_request = rx_lane_adjust_ff[PHASE_ADJ_BIT]; // RULE7
	assign rx_lane_number          = rx_lane_adjust_ff[4:0]; // RULE8
	assign rx_scramble_flag        = rx_scr_lanes_ff[SCRAMBLE_BIT]; // RULE9
	assign rx_lane_count           = rx_scr_lanes_ff[4:0]; // RULE10

	// ************************************************************
	// read-back
	// ************************************************************
	// unmapped addresses read as zero
	always_comb begin
		case (bus.addr)
			ADDR_TPL_CONTROL:    bus.rdata = tpl_control_ff;
			ADDR_TPL_REF_LOW:    bus.rdata = expected_sample_low;
			ADDR_TPL_REF_HIGH:   bus.rdata = expected_sample_high;
			ADDR_TPL_RESULT:     bus.rdata = {7'h00, transport_test_mismatch}; // RULE2
			ADDR_LANE_INVERT:    bus.rdata = lane_invert_mask;
			ADDR_RX_DEVICE_ID:   bus.rdata = rx_device_identifier; // RULE4
			ADDR_RX_BANK_ID:     bus.rdata = rx_bank_identifier; // RULE5
			ADDR_RX_LANE_ADJUST: bus.rdata = {1'b0, rx_adjust_direction,
				rx_phase_adjust_request, rx_lane_number}; // RULE6
			ADDR_RX_SCR_LANES:   bus.rdata = {rx_scramble_flag, 2'h0,
				rx_lane_count}; // RULE9
			ADDR_RX_OCTETS:      bus.rdata = rx_octets_ff; // RULE11
			ADDR_RX_FRAMES_MF:   bus.rdata = rx_frames_mf_ff;
			default:             bus.rdata = 8'h00;
		endcase
	end

endmodule

`default_nettype wire

// ==== jrx_chk.sv ====
`timescale 1ns/1ps
`default_nettype none

module jrx_chk
	import jrx_pkg::*;
(
	input wire logic                        SYS_CLK,
	input wire logic                        RESET_N,
	input wire logic                        CLK_EN,
	input wire logic                        SPI_SCLK,
	input wire logic                        SPI_CS_N,
	input wire logic                        SPI_SDO,
	input wire logic                        SPI_SDO_OE,
	input wire logic [NUM_LANES*LANE_W-1:0] LANE_DATA_IN,
	input wire logic [NUM_LANES*LANE_W-1:0] LANE_DATA_OUT
);
	logic [3:0] cs_hi_ff;
	logic [3:0] nxt_cs_hi;
	logic [3:0] age_ff;
	logic [3:0] nxt_age;
	logic       sclk_ff;
	logic       nxt_sclk;

	// counters saturate so a long idle never wraps to a busy reading
	always_comb begin
		nxt_sclk = SPI_SCLK;
		nxt_cs_hi = SPI_CS_N ? cs_hi_ff + {3'h0, cs_hi_ff != 4'hF} : 4'h0;
		nxt_age = age_ff + {3'h0, age_ff != 4'hF};
		if (sclk_ff && !SPI_SCLK) begin
			nxt_age = 4'h0;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			cs_hi_ff <= 4'h0;
			age_ff <= 4'hF;
			sclk_ff <= 1'b0;
		end else begin
			cs_hi_ff <= nxt_cs_hi;
			age_ff <= nxt_age;
			sclk_ff <= nxt_sclk;
		end
	end

	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RESET_N);

	// two enabled edges with the port idle: mask cannot move
	sequence s_quiet_run;
		CLK_EN ##1 CLK_EN ##1 cs_hi_ff == 4'hF;
	endsequence

	a_lane_xor: assert property (s_quiet_run |->
		(LANE_DATA_OUT ^ $past(LANE_DATA_IN)) ==
		($past(LANE_DATA_OUT) ^ $past(LANE_DATA_IN, 2)))
		else $error("lane output not input xor fixed mask");
	a_reset_quiet: assert property (disable iff (1'b0)
		!RESET_N |-> LANE_DATA_OUT == '0 && !SPI_SDO_OE && !SPI_SDO)
		else $error("outputs not zero in reset");
	a_freeze_lane: assert property (!CLK_EN |=> $stable(LANE_DATA_OUT))
		else $error("lane output moved with clock enable low");
	a_freeze_oe: assert property (!CLK_EN |=> $stable(SPI_SDO_OE))
		else $error("sdo enable moved with clock enable low");
	a_oe_cause: assert property ($rose(SPI_SDO_OE) |->
		!$past(SPI_CS_N, 3) && age_ff <= 4'h6)
		else $error("sdo enable rose without select and clock fall");
	a_sdo_shift: assert property (SPI_SDO_OE && $past(SPI_SDO_OE)
		&& $changed(SPI_SDO) |-> age_ff <= 4'h6)
		else $error("sdo changed away from a clock fall");
	a_oe_hold: assert property (SPI_SDO_OE && !SPI_CS_N
		&& !$past(SPI_CS_N, 4) |=> SPI_SDO_OE)
		else $error("sdo enable dropped inside frame");
	a_oe_release: assert property (SPI_SDO_OE |-> cs_hi_ff <= 4'h4)
		else $error("sdo enable held after deselect");
endmodule

bind jesd_rx_test_and_ilas_capture jrx_chk u_chk (
	.SYS_CLK       (SYS_CLK),
	.RESET_N       (RESET_N),
	.CLK_EN        (CLK_EN),
	.SPI_SCLK      (SPI_SCLK),
	.SPI_CS_N      (SPI_CS_N),
	.SPI_SDO       (SPI_SDO),
	.SPI_SDO_OE    (SPI_SDO_OE),
	.LANE_DATA_IN  (LANE_DATA_IN),
	.LANE_DATA_OUT (LANE_DATA_OUT)
);

`default_nettype wire

// ==== jtx_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module jtx_model
	import jrx_pkg::*;
(
	input  wire logic                         clk,
	output var  logic [NUM_LANES*LANE_W-1:0]  lane_data,
	output var  logic                         smp_valid,
	output var  logic [NUM_CONV*SAMPLE_W-1:0] smp_data,
	output var  logic                         cfg_valid,
	output var  logic [ILAS_W-1:0]            cfg_data
);
	initial begin
		lane_data = '0;
		smp_valid = 1'b0;
		smp_data = '0;
		cfg_valid = 1'b0;
		cfg_data = '0;
	end

	task automatic set_lanes(input logic [NUM_LANES*LANE_W-1:0] d);
		@(negedge clk);
		lane_data = d;
	endtask

	// outside its pulse the data is inverted, never left looking valid
	task automatic send_smp(input logic [NUM_CONV*SAMPLE_W-1:0] d);
		@(negedge clk);
		smp_data = d;
		smp_valid = 1'b1;
		@(negedge clk);
		smp_valid = 1'b0;
		smp_data = ~d;
	endtask

	task automatic send_cfg(input logic [ILAS_W-1:0] d);
		@(negedge clk);
		cfg_data = d;
		cfg_valid = 1'b1;
		@(negedge clk);
		cfg_valid = 1'b0;
		cfg_data = ~d;
	endtask
endmodule

`default_nettype wire

// ==== jesd_rx_test_and_ilas_capture_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module jesd_rx_test_and_ilas_capture_tb
	import jrx_pkg::*;
;
	typedef struct packed {
		logic [14:0] addr;
		logic [7:0]  wd;
		logic [7:0]  exp;
	} row_s;

	logic        sys_clk;
	logic        reset_n;
	logic        clk_en;
	logic        sclk;
	logic        cs_n;
	logic        sdi;
	logic        sdo;
	logic [63:0] lin;
	logic [63:0] lout;
	logic        sv;
	logic [63:0] sd;
	logic        cv;
	logic [47:0] cd;
	int          fails;
	int          n_checks;
	int          cyc;
	row_s        rows [6];
	logic [47:0] cfg [2];
	logic [47:0] cexp [2];
	logic [7:0]  m;

	jesd_rx_test_and_ilas_capture uut (
		.SYS_CLK(sys_clk), .RESET_N(reset_n), .CLK_EN(clk_en),
		.SPI_SCLK(sclk), .SPI_CS_N(cs_n), .SPI_SDI(sdi), .SPI_SDO(sdo),
		.SPI_SDO_OE(), .LANE_DATA_IN(lin), .LANE_DATA_OUT(lout),
		.SAMPLE_VALID(sv), .SAMPLE_DATA(sd),
		.ILAS_CFG_VALID(cv), .ILAS_CFG_DATA(cd));

	jtx_model tx (.clk(sys_clk), .lane_data(lin), .smp_valid(sv),
		.smp_data(sd), .cfg_valid(cv), .cfg_data(cd));

	always #50 sys_clk = ~sys_clk;

	always @(posedge sys_clk) begin
		cyc = cyc + 1;
		if (cyc == 40000) begin
			fails = fails + 1;
			$display("timeout");
			test_done();
		end
	end

	task automatic chk(input string what, input logic [63:0] e, g);
		n_checks = n_checks + 1;
		if (g !== e) begin
			fails = fails + 1;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask

	// mode 0: data set while the clock is low, taken on its rise
	task automatic spi(input logic [15:0] ins, input logic [7:0] wd,
		output logic [7:0] r);
		logic [23:0] fr;
		fr = {ins, wd};
		r = 8'h00;
		@(negedge sys_clk);
		cs_n = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			sdi = fr[i];
			repeat (5) @(negedge sys_clk);
			sclk = 1'b1;
			if (i < 8) r[i] = sdo;
			repeat (5) @(negedge sys_clk);
			sclk = 1'b0;
		end
		repeat (6) @(negedge sys_clk);
		cs_n = 1'b1;
		sdi = ~sdi;
		repeat (8) @(negedge sys_clk);
	endtask

	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		logic [7:0] r;
		spi({1'b0, a}, d, r);
	endtask

	task automatic rdchk(input logic [14:0] a, input logic [7:0] e);
		logic [7:0] r;
		spi({1'b1, a}, 8'h00, r);
		chk($sformatf("reg %h", a), {56'h0, e}, {56'h0, r});
	endtask

	function automatic logic [63:0] inv(input logic [63:0] d,
		input logic [7:0] k);
		inv = d;
		for (int n = 0; n < 8; n++) inv[8*n+:8] = d[8*n+:8] ^ {8{k[n]}};
	endfunction

	// converter s carries hit, the other three its complement
	function automatic logic [63:0] smp(input int s,
		input logic [15:0] hit);
		smp = {4{~hit}};
		smp[16*s+:16] = hit;
	endfunction

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		sys_clk = 1'b0;
		reset_n = 1'b1;
		clk_en = 1'b1;
		sclk = 1'b0;
		cs_n = 1'b1;
		sdi = 1'b0;
		fails = 0;
		n_checks = 0;
		cyc = 0;
		rows[0] = {ADDR_TPL_REF_LOW, 8'hA5, 8'hA5};
		rows[1] = {ADDR_TPL_REF_HIGH, 8'h5A, 8'h5A};
		rows[2] = {ADDR_LANE_INVERT, 8'h3C, 8'h3C};
		rows[3] = {ADDR_TPL_RESULT, 8'hFF, 8'h00};
		rows[4] = {ADDR_RX_DEVICE_ID, 8'h77, 8'h00};
		rows[5] = {15'h07FF, 8'h12, 8'h00};
		cfg[0] = 48'h1F03E7FFC35A;
		cexp[0] = 48'h1F03877FC35A;
		cfg[1] = 48'hE0016120_00A5;
		cexp[1] = 48'h000101200_0A5;
		// a real falling edge, so no flop misses its reset at time zero
		#1 reset_n = 1'b0;
		repeat (16) @(negedge sys_clk);
		reset_n = 1'b1;
		repeat (4) @(negedge sys_clk);
		for (int a = 0; a < 6; a++) rdchk(ADDR_RX_DEVICE_ID + 15'(a), 8'h00);
		for (int a = 0; a < 4; a++) rdchk(ADDR_TPL_CONTROL + 15'(a), 8'h00);
		rdchk(ADDR_LANE_INVERT, 8'h00);
		$display("test reset values done");
		foreach (rows[i]) begin
			wr(rows[i].addr, rows[i].wd);
			rdchk(rows[i].addr, rows[i].exp);
		end
		$display("test register rows done");
		// ************************************************
		// configuration capture, held after the pulse
		// ************************************************
		for (int v = 0; v < 2; v++) begin
			tx.send_cfg(cfg[v]);
			for (int b = 0; b < 6; b++)
				rdchk(ADDR_RX_DEVICE_ID + 15'(b), cexp[v][8*b+:8]);
		end
		$display("test capture done");
		// ************************************************
		// sample compare, each converter, sticky fail
		// ************************************************
		wr(ADDR_TPL_REF_LOW, 8'h01);
		wr(ADDR_TPL_REF_HIGH, 8'h80);
		for (int s = 0; s < 4; s++) begin
			wr(ADDR_TPL_CONTROL, 8'h02);
			wr(ADDR_TPL_CONTROL, {4'h0, 2'(s), 2'b01});
			tx.send_smp(smp(s, 16'h8001));
			rdchk(ADDR_TPL_RESULT, 8'h00);
			tx.send_smp(smp(s, (s % 2) ? 16'h8000 : 16'h0001));
			tx.send_smp(smp(s, 16'h8001));
			rdchk(ADDR_TPL_RESULT, 8'h01);
		end
		wr(ADDR_TPL_CONTROL, 8'h03);
		tx.send_smp(smp(3, 16'h8001));
		rdchk(ADDR_TPL_RESULT, 8'h00);
		wr(ADDR_TPL_CONTROL, 8'h00);
		tx.send_smp(smp(1, 16'h8001));
		rdchk(ADDR_TPL_RESULT, 8'h00);
		$display("test sample compare done");
		// ************************************************
		// lane inversion and clock enable freeze
		// ************************************************
		for (int k = 0; k < 2; k++) begin
			m = k ? 8'h80 : 8'h01;
			wr(ADDR_LANE_INVERT, m);
			repeat (16) @(negedge sys_clk);
			tx.set_lanes(64'h0123456789ABCDEF);
			@(negedge sys_clk);
			chk("lanes", inv(64'h0123456789ABCDEF, m), lout);
		end
		clk_en = 1'b0;
		tx.set_lanes(64'hFEDCBA9876543210);
		repeat (2) @(negedge sys_clk);
		chk("frozen lanes", inv(64'h0123456789ABCDEF, 8'h80), lout);
		clk_en = 1'b1;
		repeat (2) @(negedge sys_clk);
		chk("lanes", inv(64'hFEDCBA9876543210, 8'h80), lout);
		$display("test lanes done");
		// ************************************************
		// reset in mid-run drops captured and written state
		// ************************************************
		reset_n = 1'b0;
		repeat (3) @(negedge sys_clk);
		reset_n = 1'b1;
		repeat (4) @(negedge sys_clk);
		chk("lanes after reset", 64'hFEDCBA9876543210, lout);
		rdchk(ADDR_RX_DEVICE_ID, 8'h00);
		rdchk(ADDR_LANE_INVERT, 8'h00);
		rdchk(ADDR_TPL_REF_HIGH, 8'h00);
		$display("test mid-run reset done");
		test_done();
	end
endmodule

`default_nettype wire
